// ==== include/capture_timer_defines.svh ====
`ifndef CAPTURE_TIMER_DEFINES_SVH
`define CAPTURE_TIMER_DEFINES_SVH

// Register index; the byte address is four times it
`define IDX_CONTROL_A 10'h000
`define IDX_CONTROL_B 10'h001
`define IDX_EVENT_CTRL 10'h004
`define IDX_INT_MASK 10'h005
`define IDX_INT_STATUS 10'h006
`define IDX_RUN_STATUS 10'h007
`define IDX_COUNT 10'h00A
`define IDX_CAPTURE 10'h00C
`define IDX_TOP 10'h00D

`define OFF_CONTROL_A {`IDX_CONTROL_A, 2'b00}
`define OFF_CONTROL_B {`IDX_CONTROL_B, 2'b00}
`define OFF_EVENT_CTRL {`IDX_EVENT_CTRL, 2'b00}
`define OFF_INT_MASK {`IDX_INT_MASK, 2'b00}
`define OFF_INT_STATUS {`IDX_INT_STATUS, 2'b00}
`define OFF_RUN_STATUS {`IDX_RUN_STATUS, 2'b00}
`define OFF_COUNT {`IDX_COUNT, 2'b00}
`define OFF_CAPTURE {`IDX_CAPTURE, 2'b00}
`define OFF_TOP {`IDX_TOP, 2'b00}

`define CA_ENABLE 0
`define CA_CLOCK_SOURCE_SELECT_LO 1
`define CA_CLOCK_SOURCE_SELECT_HI 2
`define CA_SYNC 4
`define CA_STANDBY 6
`define CB_MODE_LO 0
`define CB_MODE_HI 2
`define CB_GATE 4
`define CB_INIT 5
`define CB_START_A 6
`define EV_ENABLE 0
`define EV_EDGE 4
`define EV_FILTER 6

`define CTRL_RESET 8'h00
`define TOP_RESET 16'hFFFF
`define FILTER_SAMPLES 4

`endif

// ==== include/capture_timer_pkg.sv ====
package capture_timer_pkg;

typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PULSE = 3'h4,
    MODE_FREQ_PULSE = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM8 = 3'h7
} counter_mode_type;

typedef enum logic [1:0] {
    CLK_PERIPH = 2'h0,
    CLK_PERIPH_DIV2 = 2'h1,
    CLK_COMPANION = 2'h2,
    CLK_RESERVED = 2'h3
} clock_source_type;

// One-hot phases of the combined frequency and pulse-width sequence
typedef enum logic [2:0] {
    FP_IDLE = 3'b001,
    FP_HIGH = 3'b010,
    FP_LOW = 3'b100
} fp_state_type;

endpackage : capture_timer_pkg

// ==== hdl/capture_timer_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_defines.svh"

// Functional notes
// - Standby run keeps timer going, except companion clock
// - Sync bit restarts counter with companion restart
// - Clock select: periph, periph/2, companion
// - Enable bit gates all timer operation
// - Single-shot output rises at start or event
// - Initial level bit sets output level outside single and PWM modes
// - Output gate clear forces output zero
// - Mode field selects one of eight modes
// - Filter bit enables noise filter
// - Edge bit selects polarity per mode
// - Periodic mode ignores all events
// - Capture mode captures and interrupts on edge
// - Frequency mode captures, restarts, interrupts
// - Pulse mode restarts then captures opposite edge
// - Combined mode restart, capture, stop, interrupt
// - Event actions only when input enable set
// - Filter passes level after four equal samples
// - Flag clears on write one, status read, or capture read in capture modes
module capture_timer_control
    import capture_timer_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event and companion timer
    input wire logic event_in,
    input wire logic companion_timer_clock,
    input wire logic companion_restart,
    // Power
    input wire logic standby_sleep,
    // Outputs
    output logic compare_out,
    output logic irq
);

    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] event_input_control;
    logic int_mask;
    logic capture_interrupt_flag;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] top;
    logic running;
    logic div_phase;
    logic [1:0] ev_sync;
    logic [1:0] ct_sync;
    logic [1:0] cr_sync;
    logic ct_prev;
    logic cr_prev;
    logic [`FILTER_SAMPLES-1:0] filt_hist;
    logic filt_level;
    logic ev_prev;
    logic shot_out;
    fp_state_type fp_state;

    wire apb_setup = psel && !penable;
    wire apb_write = psel && penable && pwrite && pready;
    wire apb_read = psel && penable && !pwrite && pready;
    wire addr_ok = (paddr == `OFF_CONTROL_A) || (paddr == `OFF_CONTROL_B) ||
        (paddr == `OFF_EVENT_CTRL) || (paddr == `OFF_INT_MASK) ||
        (paddr == `OFF_INT_STATUS) || (paddr == `OFF_RUN_STATUS) ||
        (paddr == `OFF_COUNT) || (paddr == `OFF_CAPTURE) || (paddr == `OFF_TOP);

    counter_mode_type mode;
    clock_source_type clk_sel;
    assign mode = counter_mode_type'(timer_control_b[`CB_MODE_HI:`CB_MODE_LO]);
    assign clk_sel = clock_source_type'(timer_control_a[`CA_CLOCK_SOURCE_SELECT_HI:`CA_CLOCK_SOURCE_SELECT_LO]);

    wire active = timer_control_a[`CA_ENABLE] &&
        !(standby_sleep && (!timer_control_a[`CA_STANDBY] || clk_sel == CLK_COMPANION));
    logic tick;
    always_comb begin
        case (clk_sel)
            CLK_PERIPH: tick = 1'b1;
            CLK_PERIPH_DIV2: tick = div_phase;
            CLK_COMPANION: tick = ct_sync[1] && !ct_prev;
            default: tick = 1'b0;
        endcase
    end
    // Pin inputs pass two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_sync <= 2'b00;
            ct_sync <= 2'b00;
            cr_sync <= 2'b00;
            ct_prev <= 1'b0;
            cr_prev <= 1'b0;
            div_phase <= 1'b0;
        end else begin
            ev_sync <= {ev_sync[0], event_in};
            ct_sync <= {ct_sync[0], companion_timer_clock};
            cr_sync <= {cr_sync[0], companion_restart};
            ct_prev <= ct_sync[1];
            cr_prev <= cr_sync[1];
            div_phase <= !div_phase;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_hist <= '0;
            filt_level <= 1'b0;
            ev_prev <= 1'b0;
        end else begin
            filt_hist <= {filt_hist[`FILTER_SAMPLES-2:0], ev_sync[1]};
            if (!event_input_control[`EV_FILTER])
                filt_level <= ev_sync[1];
            else if (&filt_hist || ~|filt_hist)
                filt_level <= filt_hist[0];
            ev_prev <= filt_level;
        end
    end
    wire rise = filt_level && !ev_prev;
    wire fall = !filt_level && ev_prev;
    wire ev_ok = active && event_input_control[`EV_ENABLE];
    wire edge_sel = event_input_control[`EV_EDGE];
    wire pos_ev = ev_ok && (edge_sel ? fall : rise);
    wire neg_ev = ev_ok && (edge_sel ? rise : fall);
    wire sync_restart = active && timer_control_a[`CA_SYNC] && cr_sync[1] && !cr_prev;
    wire at_top = (count == top);
    // Event actions per mode
    logic ev_capture, ev_restart, ev_start, ev_stop, ev_irq;
    always_comb begin
        ev_capture = 1'b0;
        ev_restart = 1'b0;
        ev_start = 1'b0;
        ev_stop = 1'b0;
        ev_irq = 1'b0;
        case (mode)
            MODE_PERIODIC: ev_irq = running && tick && at_top;
            MODE_TIMEOUT: begin
                ev_start = pos_ev;
                ev_stop = neg_ev;
                ev_irq = running && tick && at_top;
            end
            MODE_CAPTURE: begin
                ev_capture = pos_ev;
                ev_irq = pos_ev;
            end
            MODE_FREQ: begin
                ev_capture = pos_ev;
                ev_restart = pos_ev;
                ev_irq = pos_ev;
            end
            MODE_PULSE: begin
                ev_restart = pos_ev;
                ev_capture = neg_ev;
                ev_irq = neg_ev;
            end
            MODE_FREQ_PULSE: begin
                ev_restart = pos_ev && (fp_state == FP_IDLE);
                ev_capture = neg_ev && (fp_state == FP_HIGH);
                ev_stop = pos_ev && (fp_state == FP_LOW);
                ev_irq = ev_stop;
            end
            MODE_SINGLE: begin
                ev_start = pos_ev && !running;
                ev_irq = running && tick && at_top;
                ev_stop = ev_irq;
            end
            MODE_PWM8: ev_irq = running && tick && (count[7:0] == top[15:8]);
            default: ev_irq = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fp_state <= FP_IDLE;
        else if (mode != MODE_FREQ_PULSE || !active)
            fp_state <= FP_IDLE;
        else begin
            case (fp_state)
                FP_IDLE: if (pos_ev) fp_state <= FP_HIGH;
                FP_HIGH: if (neg_ev) fp_state <= FP_LOW;
                FP_LOW: if (pos_ev) fp_state <= FP_IDLE;
                default: fp_state <= FP_IDLE;
            endcase
        end
    end

    // Counter; bus write wins over internal update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            running <= 1'b0;
        end else if (apb_write && paddr == `OFF_COUNT) begin
            count <= pwdata[15:0];
        end else if (!active) begin
            running <= 1'b0;
        end else begin
            if (ev_restart || sync_restart) begin
                count <= 16'h0000;
                running <= 1'b1;
            end else if (ev_stop) begin
                running <= 1'b0;
            end else if (ev_start) begin
                running <= 1'b1;
            end else if (mode == MODE_PERIODIC || mode == MODE_PWM8) begin
                running <= 1'b1;
                if (tick)
                    count <= (mode == MODE_PWM8 && count[7:0] >= top[7:0]) || at_top ? 16'h0000 : count + 16'h0001;
            end else if (running && tick) begin
                count <= at_top ? 16'h0000 : count + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            capture <= 16'h0000;
        else if (active && ev_capture)
            capture <= count;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            shot_out <= 1'b0;
        else if (!active || mode != MODE_SINGLE || ev_stop)
            shot_out <= 1'b0;
        else if (timer_control_b[`CB_START_A] ? pos_ev : (running && tick))
            shot_out <= 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            compare_out <= 1'b0;
        else if (!timer_control_b[`CB_GATE])
            compare_out <= 1'b0;
        else if (mode == MODE_SINGLE)
            compare_out <= shot_out;
        else if (mode == MODE_PWM8)
            compare_out <= running && (count[7:0] < top[15:8]);
        else
            compare_out <= timer_control_b[`CB_INIT];
    end
    wire capture_interrupt_flag_mode = (mode == MODE_CAPTURE) || (mode == MODE_FREQ) ||
        (mode == MODE_PULSE) || (mode == MODE_FREQ_PULSE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            capture_interrupt_flag <= 1'b0;
        else if (active && ev_irq)
            capture_interrupt_flag <= 1'b1;
        else if ((apb_write && paddr == `OFF_INT_STATUS && pwdata[0]) ||
                 (apb_read && paddr == `OFF_INT_STATUS) ||
                 (apb_read && paddr == `OFF_CAPTURE && capture_interrupt_flag_mode))
            capture_interrupt_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= capture_interrupt_flag && int_mask;
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a <= `CTRL_RESET;
            timer_control_b <= `CTRL_RESET;
            event_input_control <= `CTRL_RESET;
            int_mask <= 1'b0;
            top <= `TOP_RESET;
        end else if (apb_write) begin
            case (paddr)
                `OFF_CONTROL_A: timer_control_a <= pwdata[7:0] & 8'h57;
                `OFF_CONTROL_B: timer_control_b <= pwdata[7:0] & 8'h77;
                `OFF_EVENT_CTRL: event_input_control <= pwdata[7:0] & 8'h51;
                `OFF_INT_MASK: int_mask <= pwdata[0];
                `OFF_TOP: top <= pwdata[15:0];
                default: int_mask <= int_mask;
            endcase
        end
    end

    // No wait state; read data is registered during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            prdata <= 32'h00000000;
            if (apb_setup && !pwrite) begin
                case (paddr)
                    `OFF_CONTROL_A: prdata <= {24'h000000, timer_control_a};
                    `OFF_CONTROL_B: prdata <= {24'h000000, timer_control_b};
                    `OFF_EVENT_CTRL: prdata <= {24'h000000, event_input_control};
                    `OFF_INT_MASK: prdata <= {31'h0, int_mask};
                    `OFF_INT_STATUS: prdata <= {31'h0, capture_interrupt_flag};
                    `OFF_RUN_STATUS: prdata <= {31'h0, running};
                    `OFF_COUNT: prdata <= {16'h0000, count};
                    `OFF_CAPTURE: prdata <= {16'h0000, capture};
                    `OFF_TOP: prdata <= {16'h0000, top};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    capture_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        (active && mode == MODE_CAPTURE && pos_ev) |=> capture == $past(count))
        else $error("capture not loaded on selected edge");
    periodic_noevent_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_PERIODIC) |-> !ev_capture && !ev_restart)
        else $error("event acted in periodic mode");
    gate_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_control_b[`CB_GATE] |=> !compare_out)
        else $error("output not zero with gate clear");
    disabled_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        !timer_control_a[`CA_ENABLE] ##1 !timer_control_a[`CA_ENABLE] |-> !running)
        else $error("counter runs while disabled");
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        (active && ev_irq) |=> capture_interrupt_flag)
        else $error("flag not set on event");
    freq_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (active && mode == MODE_FREQ && pos_ev && !(apb_write && paddr == `OFF_COUNT)) |=> count == 16'h0000)
        else $error("counter not cleared in frequency mode");
    event_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !event_input_control[`EV_ENABLE] |-> !pos_ev && !neg_ev)
        else $error("event passed while input disabled");
    init_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_control_b[`CB_GATE] && mode == MODE_CAPTURE) |=> compare_out == $past(timer_control_b[`CB_INIT]))
        else $error("output not at initial level");

endmodule : capture_timer_control
`default_nettype wire

// ==== bench/companion_event_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module companion_event_model (
    // Clock
    input wire logic pclk,
    // Far-side lines
    output logic event_in,
    output logic companion_timer_clock,
    output logic companion_restart
);
    logic [1:0] div = 2'h0;

    initial begin
        event_in = 1'b0;
        companion_restart = 1'b0;
    end

    // Free-running tick, quarter rate, so a halved clock is distinguishable
    always @(posedge pclk) begin
        div <= div + 2'h1;
    end
    assign companion_timer_clock = div[1];

    task automatic set_event(input logic v);
        @(posedge pclk);
        event_in <= v;
    endtask : set_event

    // Held four cycles so the synchroniser cannot miss it
    task automatic restart_pulse();
        @(posedge pclk);
        companion_restart <= 1'b1;
        repeat (4) @(posedge pclk);
        companion_restart <= 1'b0;
    endtask : restart_pulse
endmodule : companion_event_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "capture_timer_defines.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, standby_sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, event_in, ctick, crestart, compare_out, irq;
    int n_fail = 0;
    int num_checks = 0;

    capture_timer_control i_capture_timer_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .event_in(event_in), .companion_timer_clock(ctick),
        .companion_restart(crestart), .standby_sleep(standby_sleep), .compare_out(compare_out),
        .irq(irq));
    companion_event_model i_companion_event_model (.pclk(pclk), .event_in(event_in),
        .companion_timer_clock(ctick), .companion_restart(crestart));

    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Master waits for pready, holds everything until that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(`OFF_CONTROL_A, q);
        chk(q, 32'h0);
        rd(`OFF_CONTROL_B, q);
        chk(q, 32'h0);
        rd(`OFF_EVENT_CTRL, q);
        chk(q, 32'h0);
        wr(`OFF_CONTROL_A, 32'h56);
        rd(`OFF_CONTROL_A, q);
        chk(q, 32'h56);
        wr(`OFF_CONTROL_A, 32'h0);
        wr(`OFF_CONTROL_B, 32'h77);
        rd(`OFF_CONTROL_B, q);
        chk(q, 32'h77);
        wr(`OFF_EVENT_CTRL, 32'h51);
        rd(`OFF_EVENT_CTRL, q);
        chk(q, 32'h51);
        apb(1'b0, 12'hFFC, 32'h0, q, e);
        chk(e, 32'h1);
        chk(q, 32'h0);
    endtask : t_regs

    // Count over a fixed span per source except companion, standby state and enable
    task automatic t_clock();
        logic [7:0] ca [6] = '{8'h01, 8'h03, 8'h07, 8'h01, 8'h41, 8'h00};
        logic sl [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        int lo [6] = '{35, 17, 0, 0, 35, 0};
        int hi [6] = '{50, 26, 0, 0, 50, 0};
        logic [31:0] q;
        wr(`OFF_CONTROL_B, 32'h0);
        for (int i = 0; i < 6; i++) begin
            standby_sleep <= sl[i];
            wr(`OFF_COUNT, 32'h0);
            wr(`OFF_CONTROL_A, {24'h0, ca[i]});
            repeat (40) @(posedge pclk);
            wr(`OFF_CONTROL_A, 32'h0);
            rd(`OFF_COUNT, q);
            chk(q >= lo[i] && q <= hi[i], 32'h1);
        end
        standby_sleep <= 1'b0;
    endtask : t_clock

    task automatic t_sync();
        logic [31:0] q;
        for (int s = 0; s < 2; s++) begin
            wr(`OFF_COUNT, 32'h0);
            wr(`OFF_CONTROL_A, s ? 32'h15 : 32'h05);
            repeat (60) @(posedge pclk);
            i_companion_event_model.restart_pulse();
            repeat (3) @(posedge pclk);
            rd(`OFF_COUNT, q);
            wr(`OFF_CONTROL_A, 32'h0);
            chk(s ? q < 6 : q >= 12, 32'h1);
        end
    endtask : t_sync

    // Two event pulses per mode except PWM and per edge; flag after each edge, run and output in timeout and single modes
    task automatic t_events();
        logic [7:0] cb [15] = '{8'h12, 8'h12, 8'h12, 8'h10, 8'h10, 8'h13, 8'h13, 8'h14,
                                8'h14, 8'h15, 8'h15, 8'h11, 8'h11, 8'h16, 8'h56};
        logic [7:0] ev [15] = '{8'h01, 8'h11, 8'h00, 8'h01, 8'h11, 8'h01, 8'h11, 8'h01,
                                8'h11, 8'h01, 8'h11, 8'h01, 8'h11, 8'h01, 8'h11};
        logic [3:0] fl [15] = '{4'hA, 4'h5, 4'h0, 4'h0, 4'h0, 4'hA, 4'h5, 4'h5,
                                4'hA, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
        logic [3:0] rn [15] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
                                4'h0, 4'h0, 4'h0, 4'hA, 4'h5, 4'hF, 4'h7};
        logic [31:0] q;
        logic single;
        for (int i = 0; i < 15; i++) begin
            single = (cb[i][2:0] == 3'h6);
            wr(`OFF_CONTROL_A, 32'h0);
            wr(`OFF_CONTROL_B, {24'h0, cb[i]});
            wr(`OFF_EVENT_CTRL, {24'h0, ev[i]});
            wr(`OFF_INT_MASK, 32'h1);
            wr(`OFF_INT_STATUS, 32'h1);
            wr(`OFF_CONTROL_A, 32'h1);
            for (int k = 0; k < 4; k++) begin
                i_companion_event_model.set_event(k % 2 == 0);
                repeat (12) @(posedge pclk);
                chk(irq, fl[i][3-k]);
                rd(`OFF_INT_STATUS, q);
                chk(q[0], fl[i][3-k]);
                if (cb[i][2:0] == 3'h1 || single) begin
                    rd(`OFF_RUN_STATUS, q);
                    chk(q[0], rn[i][3-k]);
                    chk(compare_out, single ? rn[i][3-k] : 1'b0);
                end
            end
        end
        wr(`OFF_CONTROL_A, 32'h0);
    endtask : t_events

    task automatic t_filter();
        logic [7:0] ev [3] = '{8'h41, 8'h01, 8'h41};
        int w [3] = '{2, 2, 8};
        logic ex [3] = '{1'b0, 1'b1, 1'b1};
        logic [31:0] q;
        wr(`OFF_CONTROL_B, 32'h12);
        wr(`OFF_CONTROL_A, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_EVENT_CTRL, {24'h0, ev[i]});
            wr(`OFF_INT_STATUS, 32'h1);
            i_companion_event_model.set_event(1'b1);
            repeat (w[i] - 1) @(posedge pclk);
            i_companion_event_model.set_event(1'b0);
            repeat (14) @(posedge pclk);
            chk(irq, ex[i]);
            wr(`OFF_INT_MASK, 32'h0);
            repeat (2) @(posedge pclk);
            chk(irq, 32'h0);
            wr(`OFF_INT_MASK, 32'h1);
            repeat (2) @(posedge pclk);
            chk(irq, ex[i]);
            wr(`OFF_INT_STATUS, 32'h1);
            repeat (2) @(posedge pclk);
            chk(irq, 32'h0);
        end
    endtask : t_filter

    task automatic t_out();
        logic [7:0] cb [3] = '{8'h32, 8'h22, 8'h12};
        wr(`OFF_CONTROL_A, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_CONTROL_B, {24'h0, cb[i]});
            repeat (3) @(posedge pclk);
            chk(compare_out, cb[i] == 8'h32);
        end
        wr(`OFF_CONTROL_A, 32'h0);
    endtask : t_out

    // Frozen count is captured; reading capture clears the flag
    task automatic t_capture();
        logic [31:0] q;
        wr(`OFF_CONTROL_B, 32'h12);
        wr(`OFF_EVENT_CTRL, 32'h01);
        wr(`OFF_COUNT, 32'h1234);
        wr(`OFF_INT_STATUS, 32'h1);
        wr(`OFF_INT_MASK, 32'h1);
        wr(`OFF_CONTROL_A, 32'h1);
        i_companion_event_model.set_event(1'b1);
        repeat (12) @(posedge pclk);
        chk(irq, 32'h1);
        rd(`OFF_CAPTURE, q);
        chk(q, 32'h1234);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h0);
        i_companion_event_model.set_event(1'b0);
        repeat (12) @(posedge pclk);
        wr(`OFF_CONTROL_A, 32'h0);
    endtask : t_capture

    // PWM period is low byte plus one, high for high-byte cycles
    task automatic t_pwm();
        int highs;
        highs = 0;
        wr(`OFF_TOP, 32'h0204);
        wr(`OFF_COUNT, 32'h0);
        wr(`OFF_INT_STATUS, 32'h1);
        wr(`OFF_CONTROL_B, 32'h17);
        wr(`OFF_CONTROL_A, 32'h1);
        repeat (10) @(posedge pclk);
        for (int c = 0; c < 20; c++) begin
            @(posedge pclk);
            highs += compare_out;
        end
        wr(`OFF_CONTROL_A, 32'h0);
        chk(highs, 32'd8);
        chk(irq, 32'h1);
    endtask : t_pwm

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        standby_sleep = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_clock();
        t_sync();
        t_events();
        t_filter();
        t_out();
        t_capture();
        t_pwm();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
